// ---- shared/hbw_pkg.sv ----
// Purpose: constants and carrier types for the host bridge window and graphics control block
// Assumes: registers sit in the configuration space of the host bridge, byte-addressed
// Notes: configuration accesses are dword-wide with byte enables
//
// Overview of operation
// RQ1 - window base field sits in bits 31:12, giving the window's upper address bits
// RQ2 - window is an aligned 4 KB block below 4 GB; only bits above 11 compared
// RQ3 - with the enable bit clear (reset 0) no memory access is claimed by the window
// RQ4 - with the enable bit set, accesses inside the window are claimed and decoded
// RQ5 - after reset the window is off until software writes the enable bit to 1
// RQ6 - window hits go only to registers, never to memory, and alias nothing standard
// RQ7 - boot firmware programs the base; system software then uses it
// RQ8 - size select sits in graphics control bits 6:4, resets to 011
// RQ9 - size 000: nothing pre-allocated, no legacy video claim, sub-class reads 80h
// RQ10 - size 001: unified memory with 1 MB frame buffer
// RQ11 - size 011: unified memory with 8 MB frame buffer
// RQ12 - once the smram lock is set, size select ignores writes
// RQ13 - firmware pre-allocates graphics memory only with internal graphics enabled
// RQ14 - decode disable 0 (reset 0): legacy video cycles claimed, sub-class reads 00
// RQ15 - decode disable 1: legacy video cycles not claimed, sub-class reads 80h
// RQ16 - reserved bits read zero, ignore writes; reserved sizes mean no pre-allocation

package hbw_pkg;

   // ************************************************************
   // configuration space offsets
   // ************************************************************
   localparam logic [7:0] CFG_OFF_WINDOW = 8'h4C;
   localparam logic [7:0] CFG_OFF_GFX_CTRL = 8'h52;
   localparam logic [7:0] CFG_DWORD_GFX_CTRL = 8'h50;
   localparam int unsigned GFX_CTRL_LANE = 2; // first byte lane of graphics control

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int unsigned WIN_BASE_LSB = 12;
   localparam int unsigned WIN_BASE_MSB = 31;
   localparam int unsigned WIN_EN_BIT = 0;
   localparam logic [31:0] WIN_RESET = 32'h0000_0000;
   localparam int unsigned GMS_LSB = 4;
   localparam int unsigned GMS_MSB = 6;
   localparam int unsigned VGA_DIS_BIT = 1;
   localparam logic [15:0] GFX_CTRL_RESET = 16'h0030;

   // ************************************************************
   // encodings
   // ************************************************************
   localparam logic [2:0] GMS_NONE = 3'h0;
   localparam logic [2:0] GMS_1MB = 3'h1;
   localparam logic [2:0] GMS_8MB = 3'h3;
   localparam logic [3:0] PREALLOC_1MB = 4'h1;
   localparam logic [3:0] PREALLOC_8MB = 4'h8;
   localparam logic [7:0] SUBCLASS_VGA = 8'h00;
   localparam logic [7:0] SUBCLASS_OTHER = 8'h80;

   // configuration request carrier
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } hbw_cfg_req_t;

   // memory access presented for window decode
   typedef struct packed {
      logic [31:0] addr;
      logic wr;
   } hbw_mem_req_t;

   // graphics-side decode results
   typedef struct packed {
      logic vga_claim;
      logic [7:0] subclass;
      logic uma_mode;
      logic [3:0] prealloc_mb;
   } hbw_gfx_stat_t;

endpackage : hbw_pkg

// ---- hw/hbw_regs.sv ----
// Purpose: root-complex window register, graphics control register and their decode
// Assumes: one 40 MHz clock; smram_lock and all requests come from logic on this clock
// Notes: config answers one cycle after the request; window decode is registered

`timescale 1ns/1ps

module hbw_regs #(
   parameter int unsigned ADDR_W = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cfg_valid,
   input hbw_pkg::hbw_cfg_req_t cfg_req,
   output logic cfg_ack,
   output logic cfg_hit,
   output logic [31:0] cfg_rdata,
   input wire logic mem_valid,
   input hbw_pkg::hbw_mem_req_t mem_req,
   output logic win_claim,
   output logic win_wr,
   output logic [11:0] win_offset,
   input wire logic smram_lock,
   output hbw_pkg::hbw_gfx_stat_t gfx_stat
);

   // ************************************************************
   // elaboration checks
   // ************************************************************
   // the window is 4 KB, so at least 13 address bits; nothing above 32 exists
   if (ADDR_W < 13 || ADDR_W > 32) begin : g_bad_addr_w
      $error("hbw_regs: ADDR_W must lie in 13..32");
   end

   // graphics control must share the dword that the decode uses, at the lane it reads
   if (hbw_pkg::CFG_OFF_GFX_CTRL[7:2] != hbw_pkg::CFG_DWORD_GFX_CTRL[7:2]) begin : g_bad_dword
      $error("hbw_regs: graphics control offset lies outside its dword");
   end
   if (hbw_pkg::CFG_OFF_GFX_CTRL[1:0] != 2'(hbw_pkg::GFX_CTRL_LANE)) begin : g_bad_lane
      $error("hbw_regs: graphics control lane disagrees with its offset");
   end

   // the size field is three bits in the low byte; the view and merge assume that
   if (hbw_pkg::GMS_MSB - hbw_pkg::GMS_LSB != 2 || hbw_pkg::GMS_MSB > 7) begin : g_bad_gms
      $error("hbw_regs: size select must be three bits in the low byte");
   end

   // the decode disable bit must not overlap the size field
   if (hbw_pkg::VGA_DIS_BIT >= hbw_pkg::GMS_LSB) begin : g_bad_vga_bit
      $error("hbw_regs: decode disable bit overlaps the size field");
   end

   // the base is exactly the twenty address bits above the 4 KB block
   if (hbw_pkg::WIN_BASE_MSB - hbw_pkg::WIN_BASE_LSB != 19) begin : g_bad_base
      $error("hbw_regs: window base must be twenty bits wide");
   end
   if (hbw_pkg::WIN_EN_BIT >= hbw_pkg::WIN_BASE_LSB) begin : g_bad_en_bit
      $error("hbw_regs: enable bit overlaps the window base");
   end

   // ************************************************************
   // helper functions
   // ************************************************************
   // decide whether a size select code gives a real pre-allocation
   function automatic logic gms_valid(input logic [2:0] code);
      logic ok;
      ok = 1'b0;
      case (code)
         hbw_pkg::GMS_1MB: ok = 1'b1;  // [RQ10]
         hbw_pkg::GMS_8MB: ok = 1'b1;  // [RQ11]
         default: ok = 1'b0;           // none and reserved codes [RQ9] [RQ16]
      endcase
      return ok;
   endfunction : gms_valid

   // frame buffer size in megabytes for a size select code
   function automatic logic [3:0] gms_megabytes(input logic [2:0] code);
      logic [3:0] mb;
      mb = 4'h0;
      case (code)
         hbw_pkg::GMS_1MB: mb = hbw_pkg::PREALLOC_1MB; // [RQ10]
         hbw_pkg::GMS_8MB: mb = hbw_pkg::PREALLOC_8MB; // [RQ11]
         default: mb = 4'h0;                           // [RQ9] [RQ16]
      endcase
      return mb;
   endfunction : gms_megabytes

   // merge write data into a byte lane under its enable
   function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic en);
      return en ? new_v : old_v;
   endfunction : lane_merge

   // compare the dword part of a configuration address with a register offset
   function automatic logic dword_hit(input logic [7:0] addr, input logic [7:0] off);
      return addr[7:2] == off[7:2];
   endfunction : dword_hit

   // ************************************************************
   // register state
   // ************************************************************
   logic [19:0] win_base_r;
   logic win_en_r;
   logic [2:0] gms_r;
   logic vga_dis_r;

   // access decode of the incoming configuration request
   logic hit_window;
   logic hit_gfx;
   logic [31:0] win_wmerge;
   logic [7:0] gfx_wmerge;
   logic [31:0] win_view;
   logic [31:0] gfx_view;

   assign hit_window = dword_hit(cfg_req.addr, hbw_pkg::CFG_OFF_WINDOW);
   assign hit_gfx = dword_hit(cfg_req.addr, hbw_pkg::CFG_DWORD_GFX_CTRL);

   // qualified strobes; the register processes and the answer share them
   logic wr_window;
   logic wr_gfx;
   logic rd_strobe;
   assign wr_window = cfg_valid && cfg_req.wr && hit_window;
   assign wr_gfx = cfg_valid && cfg_req.wr && hit_gfx;
   assign rd_strobe = cfg_valid && !cfg_req.wr;

   // read views; every bit not listed below reads as zero [RQ16]
   always_comb begin
      win_view = 32'h0000_0000;
      win_view[hbw_pkg::WIN_BASE_MSB:hbw_pkg::WIN_BASE_LSB] = win_base_r; // [RQ1]
      win_view[hbw_pkg::WIN_EN_BIT] = win_en_r;
      gfx_view = 32'h0000_0000;
      gfx_view[8*hbw_pkg::GFX_CTRL_LANE + hbw_pkg::GMS_LSB +: 3] = gms_r; // [RQ8]
      gfx_view[8*hbw_pkg::GFX_CTRL_LANE + hbw_pkg::VGA_DIS_BIT] = vga_dis_r;
   end

   // byte-lane merge of write data onto the current view
   always_comb begin
      win_wmerge = win_view;
      for (int i = 0; i < 4; i++) begin
         win_wmerge[8*i +: 8] = lane_merge(win_view[8*i +: 8], cfg_req.wdata[8*i +: 8],
                                           cfg_req.be[i]);
      end
      gfx_wmerge = lane_merge(gfx_view[8*hbw_pkg::GFX_CTRL_LANE +: 8],
                              cfg_req.wdata[8*hbw_pkg::GFX_CTRL_LANE +: 8],
                              cfg_req.be[hbw_pkg::GFX_CTRL_LANE]);
   end

   // ************************************************************
   // window register
   // ************************************************************
   // base and enable; reserved bits 11:1 are simply not stored [RQ16]
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         win_base_r <= hbw_pkg::WIN_RESET[hbw_pkg::WIN_BASE_MSB:hbw_pkg::WIN_BASE_LSB];
         win_en_r <= hbw_pkg::WIN_RESET[hbw_pkg::WIN_EN_BIT]; // window off after reset [RQ5]
      end else if (wr_window) begin
         win_base_r <= win_wmerge[hbw_pkg::WIN_BASE_MSB:hbw_pkg::WIN_BASE_LSB]; // [RQ1] [RQ7]
         win_en_r <= win_wmerge[hbw_pkg::WIN_EN_BIT]; // software turns it on [RQ5]
      end
   end

   // ************************************************************
   // graphics control register
   // ************************************************************
   // size select freezes under the smram lock; the decode disable bit stays writable
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gms_r <= hbw_pkg::GFX_CTRL_RESET[hbw_pkg::GMS_MSB:hbw_pkg::GMS_LSB]; // [RQ8]
      end else if (wr_gfx && !smram_lock) begin // [RQ12]
         gms_r <= gfx_wmerge[hbw_pkg::GMS_MSB:hbw_pkg::GMS_LSB]; // [RQ8] [RQ13]
      end
   end

   // legacy video decode disable
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         vga_dis_r <= hbw_pkg::GFX_CTRL_RESET[hbw_pkg::VGA_DIS_BIT]; // [RQ14]
      end else if (wr_gfx) begin
         vga_dis_r <= gfx_wmerge[hbw_pkg::VGA_DIS_BIT];
      end
   end

   // ************************************************************
   // configuration answer
   // ************************************************************
   // one-cycle ack for every request, hit only for this block's two dwords
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_ack <= 1'b0;
         cfg_hit <= 1'b0;
      end else begin
         cfg_ack <= cfg_valid;
         cfg_hit <= cfg_valid && (hit_window || hit_gfx);
      end
   end

   // read data stands one cycle and falls back to zero, so no stale word lingers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_rdata <= 32'h0000_0000;
      end else if (rd_strobe && hit_window) begin
         cfg_rdata <= win_view;
      end else if (rd_strobe && hit_gfx) begin
         cfg_rdata <= gfx_view; // low half belongs to other registers, reads zero
      end else begin
         cfg_rdata <= 32'h0000_0000; // writes and unmapped reads [RQ16]
      end
   end

   // ************************************************************
   // window decode
   // ************************************************************
   logic addr_in_space;
   logic base_match;

   // addresses beyond the decoded space never hit, even if the base aliases there
   always_comb begin
      addr_in_space = 1'b1;
      for (int b = int'(hbw_pkg::WIN_BASE_LSB); b < 32; b++) begin
         if (b >= ADDR_W && mem_req.addr[b]) begin
            addr_in_space = 1'b0;
         end
      end
   end

   // compare above bit 11 only: the block is naturally 4 KB aligned [RQ2]
   assign base_match = (mem_req.addr[hbw_pkg::WIN_BASE_MSB:hbw_pkg::WIN_BASE_LSB]
                        == win_base_r) && addr_in_space;

   // a claim needs a request, the enable and a base match, all at the same edge
   logic claim_now;
   assign claim_now = mem_valid && win_en_r && base_match; // [RQ3] [RQ4]

   // registered claim; the hit is routed to the register set, never to memory [RQ6]
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         win_claim <= 1'b0;
      end else begin
         win_claim <= claim_now; // [RQ3] [RQ4]
      end
   end

   // target holds between claims, so the register set sees a steady offset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         win_wr <= 1'b0;
         win_offset <= 12'h000;
      end else if (claim_now) begin
         win_wr <= mem_req.wr;
         win_offset <= mem_req.addr[11:0]; // [RQ4]
      end
   end

   // ************************************************************
   // graphics status outputs
   // ************************************************************
   // reserved codes count as no pre-allocation [RQ16]
   logic size_ok;
   assign size_ok = gms_valid(gms_r);

   // a reserved or zero size behaves like no pre-allocation for claim and sub-class
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gfx_stat.vga_claim <= 1'b0;
         gfx_stat.subclass <= hbw_pkg::SUBCLASS_OTHER;
         gfx_stat.uma_mode <= 1'b0;
         gfx_stat.prealloc_mb <= 4'h0;
      end else begin
         gfx_stat.uma_mode <= size_ok; // [RQ10] [RQ11]
         gfx_stat.prealloc_mb <= gms_megabytes(gms_r);
         if (size_ok && !vga_dis_r) begin
            gfx_stat.vga_claim <= 1'b1;                     // [RQ14]
            gfx_stat.subclass <= hbw_pkg::SUBCLASS_VGA;     // [RQ14]
         end else begin
            gfx_stat.vga_claim <= 1'b0;                     // [RQ9] [RQ15]
            gfx_stat.subclass <= hbw_pkg::SUBCLASS_OTHER;   // [RQ9] [RQ15]
         end
      end
   end

endmodule : hbw_regs

// ---- testbench/hbw_regs_properties.sv ----
// Purpose: port-level checks for hbw_regs
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every hbw_regs instance
`timescale 1ns/1ps
module hbw_chk #(
   parameter int unsigned ADDR_W = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cfg_valid,
   input hbw_pkg::hbw_cfg_req_t cfg_req,
   input wire logic cfg_ack,
   input wire logic cfg_hit,
   input wire logic [31:0] cfg_rdata,
   input wire logic mem_valid,
   input hbw_pkg::hbw_mem_req_t mem_req,
   input wire logic win_claim,
   input wire logic win_wr,
   input wire logic [11:0] win_offset,
   input wire logic smram_lock,
   input hbw_pkg::hbw_gfx_stat_t gfx_stat
);
   // ************
   // properties
   // ************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ack_and_hit: assert property (cfg_valid |=> cfg_ack && cfg_hit ==
      ($past(cfg_req.addr[7:2]) inside {6'h13, 6'h14})) else $error("ack or hit wrong");
   a_win_rsvd_zero: assert property (cfg_valid && !cfg_req.wr &&
      cfg_req.addr[7:2] == 6'h13 |=> cfg_rdata[11:1] == 11'h000) else $error("window rsvd");
   a_gfx_rsvd_zero: assert property (cfg_valid && !cfg_req.wr &&
      cfg_req.addr[7:2] == 6'h14 |=> (cfg_rdata & 32'hFF8D_FFFF) == 32'h0) else $error("gfx rsvd");
   a_unmapped_quiet: assert property (cfg_ack && !cfg_hit |-> cfg_rdata == 32'h0)
      else $error("unmapped data");
   a_claim_has_req: assert property (win_claim |-> $past(mem_valid)) else $error("stray claim");
   a_claim_offset: assert property (mem_valid ##1 win_claim |->
      win_offset == $past(mem_req.addr[11:0]) && win_wr == $past(mem_req.wr)) else $error("offset");
   a_subclass_vga: assert property (gfx_stat.subclass ==
      (gfx_stat.vga_claim ? 8'h00 : 8'h80)) else $error("subclass");
   a_uma_size: assert property (gfx_stat.uma_mode == (gfx_stat.prealloc_mb != 4'h0))
      else $error("uma mode");
   a_size_locked: assert property ((smram_lock && rst_b)[*3] |->
      $stable(gfx_stat.prealloc_mb)) else $error("size moved under lock");
   c_cfg_hit: cover property (cfg_ack && cfg_hit);
   c_claim: cover property (win_claim);
   c_locked_wr: cover property (smram_lock && cfg_valid && cfg_req.wr);
endmodule : hbw_chk
bind hbw_regs hbw_chk #(.ADDR_W(ADDR_W)) hbw_chk_inst (.clk(clk), .rst_b(rst_b),
   .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit),
   .cfg_rdata(cfg_rdata), .mem_valid(mem_valid), .mem_req(mem_req), .win_claim(win_claim),
   .win_wr(win_wr), .win_offset(win_offset), .smram_lock(smram_lock), .gfx_stat(gfx_stat));

// ---- testbench/tb.sv ----
// Purpose: directed bench for hbw_regs
// Assumes: inputs move on the rising edge by non-blocking assignment
// Notes: each scenario task judges its own results; chk, cfg, mem and tally_and_finish are helpers
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cfg_valid = 1'b0;
   hbw_pkg::hbw_cfg_req_t cfg_req = '0;
   logic cfg_ack, cfg_hit, mem_valid = 1'b0, win_claim, win_wr, smram_lock = 1'b0;
   logic [31:0] cfg_rdata, rd;
   logic [11:0] win_offset;
   hbw_pkg::hbw_mem_req_t mem_req = '0;
   hbw_pkg::hbw_gfx_stat_t gfx_stat;
   int errors = 0;
   int checks = 0;
   always #12.5 clk = ~clk;
   hbw_regs #(.ADDR_W(32)) hbw_regs_inst (.clk(clk), .rst_b(rst_b), .cfg_valid(cfg_valid),
      .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata),
      .mem_valid(mem_valid), .mem_req(mem_req), .win_claim(win_claim), .win_wr(win_wr),
      .win_offset(win_offset), .smram_lock(smram_lock), .gfx_stat(gfx_stat));
   // ************
   // helpers
   // ************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : chk
   // one config cycle; answer is sampled after the ack edge has settled
   task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d, input logic h);
      @(posedge clk);
      cfg_valid <= 1'b1;
      cfg_req <= '{w, a, 4'hF, d};
      @(posedge clk);
      cfg_valid <= 1'b0;
      #1;
      chk({cfg_ack, cfg_hit}, {1'b1, h}, "cfg ack");
      rd = cfg_rdata;
   endtask : cfg
   task automatic mem(input logic [31:0] a, input logic w, input logic c);
      @(posedge clk);
      mem_valid <= 1'b1;
      mem_req <= '{a, w};
      @(posedge clk);
      mem_valid <= 1'b0;
      #1;
      chk(win_claim, c, "claim");
      if (c) chk({win_wr, win_offset}, {w, a[11:0]}, "offset");
   endtask : mem
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // ************
   // scenarios
   // ************
   task automatic t_reset;
      cfg(1'b0, 8'h4C, 32'h0, 1'b1);
      chk(rd, 32'h0, "window reset");
      mem(32'h0000_0000, 1'b0, 1'b0);
      cfg(1'b0, 8'h50, 32'h0, 1'b1);
      chk(rd, 32'h0030_0000, "gfx reset");
      chk(32'(gfx_stat), 32'({1'b1, 8'h00, 1'b1, 4'h8}), "gfx stat reset");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_window;
      cfg(1'b1, 8'h4C, 32'hFFFF_FFFF, 1'b1);
      cfg(1'b0, 8'h4C, 32'h0, 1'b1);
      chk(rd, 32'hFFFF_F001, "window bits");
      cfg(1'b1, 8'h4C, 32'hFEDC_1001, 1'b1);
      mem(32'hFEDC_1234, 1'b1, 1'b1);
      mem(32'hFEDC_1FFF, 1'b0, 1'b1);
      mem(32'hFEDC_2000, 1'b0, 1'b0);
      mem(32'hFEDC_0FFF, 1'b1, 1'b0);
      cfg(1'b1, 8'h4C, 32'hFEDC_1000, 1'b1);
      mem(32'hFEDC_1234, 1'b0, 1'b0);
      $display("t_window done");
   endtask : t_window
   // every size code with the decode-disable bit both ways; reserved bits written as ones
   task automatic t_gfx;
      logic [2:0] sz;
      logic dis, ok;
      for (int i = 0; i < 16; i++) begin
         sz = 3'(i >> 1);
         dis = i[0];
         ok = (sz == 3'h1) || (sz == 3'h3);
         cfg(1'b1, 8'h50, {8'hFF, 1'b1, sz, 2'h3, dis, 1'b1, 16'hFFFF}, 1'b1);
         cfg(1'b0, 8'h50, 32'h0, 1'b1);
         chk(rd, {9'h000, sz, 2'h0, dis, 17'h00000}, "gfx bits");
         chk(32'(gfx_stat), 32'({ok && !dis, (ok && !dis) ? 8'h00 : 8'h80, ok,
            (sz == 3'h1) ? 4'h1 : (sz == 3'h3) ? 4'h8 : 4'h0}), "gfx stat");
      end
      $display("t_gfx done");
   endtask : t_gfx
   task automatic t_lock;
      cfg(1'b1, 8'h50, 32'h0010_0000, 1'b1);
      @(posedge clk);
      smram_lock <= 1'b1;
      cfg(1'b1, 8'h50, 32'h0032_0000, 1'b1);
      cfg(1'b0, 8'h50, 32'h0, 1'b1);
      chk(rd, 32'h0012_0000, "locked size");
      @(posedge clk);
      smram_lock <= 1'b0;
      $display("t_lock done");
   endtask : t_lock
   task automatic t_unmapped;
      cfg(1'b1, 8'h48, 32'hFFFF_FFFF, 1'b0);
      cfg(1'b0, 8'h54, 32'h0, 1'b0);
      chk(rd, 32'h0, "unmapped");
      $display("t_unmapped done");
   endtask : t_unmapped
   // partial byte enables: a lane left off keeps its old contents
   task automatic t_lanes;
      cfg(1'b1, 8'h4C, 32'h1234_5001, 1'b1);
      @(posedge clk);
      cfg_valid <= 1'b1;
      cfg_req <= '{1'b1, 8'h4C, 4'hE, 32'hABCD_EF00};
      @(posedge clk);
      cfg_valid <= 1'b0;
      #1;
      chk({cfg_ack, cfg_hit}, 2'h3, "lane ack");
      cfg(1'b0, 8'h4C, 32'h0, 1'b1);
      chk(rd, 32'hABCD_E001, "byte lanes");
      cfg(1'b1, 8'h4C, 32'h0, 1'b1);
      $display("t_lanes done");
   endtask : t_lanes
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_window();
      t_gfx();
      t_lock();
      t_unmapped();
      t_lanes();
      tally_and_finish();
   end
   // hang guard, about eighteen times the expected run length of some 110 cycles
   initial begin
      repeat (2000) @(posedge clk);
      errors++;
      tally_and_finish();
   end
endmodule : tb
